// ---- uart_tx_pkg.sv ----
// Package with register map, field positions and timing constants
package uart_tx_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
	localparam logic [3:0] ADDR_CONTROL_TWO = 4'h4;
	localparam logic [3:0] ADDR_DIVISOR     = 4'h8;
	localparam logic [3:0] ADDR_STATUS      = 4'hC;
	localparam logic [3:0] ADDR_DATA        = 4'h0;
	localparam logic       ADDR_HI_DATA     = 1'b1;

	// ----------------------------------------------------------------
	// serial_control_one fields
	// ----------------------------------------------------------------
	localparam int C1_GLOBAL_ON   = 7;
	localparam int C1_WORD_LENGTH = 6;
	localparam int C1_PARITY_ON   = 5;
	localparam int C1_PARITY_TYPE = 4;
	localparam int C1_STOP_COUNT  = 3;
	localparam int C1_BREAK       = 2;
	localparam int C1_NINTH_BIT   = 0;
	localparam logic [7:0] C1_RESET = 8'h00;

	// ----------------------------------------------------------------
	// serial_control_two fields
	// ----------------------------------------------------------------
	localparam int C2_TRANSMIT_ON = 7;
	localparam int C2_RECEIVE_ON  = 6;
	localparam int C2_HIGH_SPEED  = 5;
	localparam int C2_ADDR_DETECT = 4;
	localparam int C2_EMPTY_IRQ   = 0;
	localparam logic [7:0] C2_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h00;

	// ----------------------------------------------------------------
	// serial_status_register fields
	// ----------------------------------------------------------------
	localparam int ST_EMPTY   = 0;
	localparam int ST_TX_IDLE = 1;
	localparam int ST_RX_IDLE = 2;

	// ----------------------------------------------------------------
	// Baud timing
	// ----------------------------------------------------------------
	localparam int LOW_SPEED_DIV  = 64;
	localparam int HIGH_SPEED_DIV = 16;
	localparam int BREAK_BITS     = 13;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP,
		TX_BREAK
	} tx_state_t;

endpackage

// ---- uart_format_enable_transmitter.sv ----
// UART frame format, enable control and transmitter with Avalon-MM slave
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns

// Summary of operation
// - NRZ frame: start, 8/9 data, 1/2 stop
// - Reset format is 8 data, no parity, 1 stop
// - Even, odd or no parity selectable
// - LSB first, shared format and baud
// - Enabled pins act as serial; line idles high
// - Global disable releases pins to shared use
// - Disable empties buffers, discards residual data
// - Disable clears transmit/receive enables, sets empty and idle flags
// - Disable keeps other control and divisor; the code clears the break bit on a disabling write
// - Global disable aborts activity immediately
// - Nine-bit mode sends ninth bit as MSB
// - Top word bit serves as address bit
// - Parity or address takes top position
// - Stop count applies to transmitter only
// - Shift register reloads only after stop bits
// - Start needs data and baud shift clock
// - Transmit disable stop_count_select and resets transmitter
// - Data writes blocked while empty flag low
// - Status access then data write clears flags
// - Empty flag set when data register free
// - Write during frame waits in data register
// - Write when idle loads shifter at the next baud tick
// - Idle flag set at frame completion
// - Baud is clock over 64 or 16 (N+1)
module uart_format_enable_transmitter
	import uart_tx_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// Avalon-MM slave
	input  wire logic [3:0] avs_address_i,
	input  wire logic       avs_read_i,
	input  wire logic       avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]     avs_readdata_o,
	output logic            avs_waitrequest_o,
	// Serial pins
	input  wire logic       rx_pin_i,
	output logic            tx_pin_o,
	output logic            tx_pin_oe_o,
	output logic            rx_owned_o,
	// Interrupt request level from the empty flag
	output logic            empty_irq_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  control_one_q;
	logic [7:0]  control_two_q;
	logic [7:0]  baud_divisor_q;
	logic [7:0]  data_q;
	logic        data_ninth_q;
	logic        data_full_q;
	logic        transmit_empty_flag_q;
	logic        transmitter_idle_flag_q;
	logic        receiver_idle_flag_q;
	logic        status_seen_q;
	logic        ack_q;
	logic [1:0]  rx_sync_q;
	logic [9:0]  shift_q;
	logic [3:0]  bit_cnt_q;
	logic [3:0]  break_cnt_q;
	logic [7:0]  baud_cnt_q;
	logic [5:0]  pre_cnt_q;
	logic        stop_second_q;
	tx_state_t   state_q;

	logic        global_on;
	logic        tx_active;
	logic        baud_tick;
	logic        bus_req;
	logic        wr_ctl1;
	logic        wr_ctl2;
	logic        wr_div;
	logic        wr_data;
	logic        rd_status;
	logic        load_now;
	logic        frame_done;
	logic [9:0]  frame_word;
	logic [3:0]  frame_bits;

	assign global_on = control_one_q[C1_GLOBAL_ON];
	assign tx_active = global_on & control_two_q[C2_TRANSMIT_ON];

	// ----------------------------------------------------------------
	// Bus decode: one wait cycle, answer on second cycle
	// ----------------------------------------------------------------
	assign bus_req   = ce_i & (avs_read_i | avs_write_i) & ~ack_q;
	assign wr_ctl1   = bus_req & avs_write_i & (avs_address_i == ADDR_CONTROL_ONE)
	                   & (avs_writedata_i[31] != ADDR_HI_DATA);
	assign wr_ctl2   = bus_req & avs_write_i & (avs_address_i == ADDR_CONTROL_TWO);
	assign wr_div    = bus_req & avs_write_i & (avs_address_i == ADDR_DIVISOR);
	assign rd_status = bus_req & (avs_address_i == ADDR_STATUS);
	// Data register lives at offset 0x0, selected by bit 31 of the write word
	assign wr_data   = bus_req & avs_write_i & (avs_address_i == ADDR_DATA)
	                   & (avs_writedata_i[31] == ADDR_HI_DATA);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_q <= 1'b0;
		end else if (ce_i) begin
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if (ce_i) begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (ce_i && bus_req && avs_read_i) begin
			unique case (avs_address_i)
				ADDR_CONTROL_ONE: avs_readdata_o <= {24'h00_0000, control_one_q};
				ADDR_CONTROL_TWO: avs_readdata_o <= {24'h00_0000, control_two_q};
				ADDR_DIVISOR:     avs_readdata_o <= {24'h00_0000, baud_divisor_q};
				ADDR_STATUS:      avs_readdata_o <= {29'h0000_0000,
					receiver_idle_flag_q, transmitter_idle_flag_q,
					transmit_empty_flag_q};
				default:          avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			control_one_q <= C1_RESET;
		end else if (ce_i && wr_ctl1) begin
			control_one_q <= avs_writedata_i[7:0];
			if (!avs_writedata_i[C1_GLOBAL_ON]) begin
				control_one_q[C1_BREAK] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			control_two_q <= C2_RESET;
		end else if (ce_i) begin
			if (wr_ctl2) begin
				control_two_q <= avs_writedata_i[7:0];
			end
			if (!global_on || (wr_ctl1 && !avs_writedata_i[C1_GLOBAL_ON])) begin
				control_two_q[C2_TRANSMIT_ON] <= 1'b0;
				control_two_q[C2_RECEIVE_ON]  <= 1'b0;
			end
		end
	end

	// Divisor and other control kept across disable, except the break bit, which a disabling write clears
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			baud_divisor_q <= DIV_RESET;
		end else if (ce_i && wr_div) begin
			baud_divisor_q <= avs_writedata_i[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Baud generator: prescale 64 or 16, then divide by N+1
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_cnt_q  <= 6'h00;
			baud_cnt_q <= 8'h00;
		end else if (ce_i) begin
			if (pre_cnt_q >= (control_two_q[C2_HIGH_SPEED] ?
			    6'(HIGH_SPEED_DIV - 1) : 6'(LOW_SPEED_DIV - 1))) begin
				pre_cnt_q <= 6'h00;
				baud_cnt_q <= (baud_cnt_q >= baud_divisor_q) ? 8'h00
				              : baud_cnt_q + 8'h01;
			end else begin
				pre_cnt_q <= pre_cnt_q + 6'h01;
			end
		end
	end
	// A smaller divisor written mid-count wraps at once instead of stalling
	assign baud_tick = (baud_cnt_q >= baud_divisor_q) &
	                   (pre_cnt_q == 6'h00);

	// ----------------------------------------------------------------
	// Frame assembly
	// ----------------------------------------------------------------
	function automatic logic [9:0] build_word(input logic [7:0] d,
	                                          input logic ninth,
	                                          input logic [7:0] c1);
		logic par;
		logic [9:0] w;
		w = {1'b0, ninth, d};
		if (c1[C1_PARITY_ON]) begin
			// Parity replaces the top word bit
			if (c1[C1_WORD_LENGTH]) begin
				par = ^d ^ c1[C1_PARITY_TYPE];
				w = {1'b0, par, d};
			end else begin
				par = ^d[6:0] ^ c1[C1_PARITY_TYPE];
				w = {2'b00, par, d[6:0]};
			end
		end else if (!c1[C1_WORD_LENGTH]) begin
			w = {2'b00, d};
		end
		return w;
	endfunction

	assign frame_word = build_word(data_q, data_ninth_q, control_one_q);
	assign frame_bits = control_one_q[C1_WORD_LENGTH] ? 4'h9 : 4'h8;
	// Load from idle, or straight after the last stop bit
	assign load_now   = tx_active & data_full_q & baud_tick
	                    & ~control_one_q[C1_BREAK]
	                    & ((state_q == TX_IDLE) | frame_done);
	assign frame_done = baud_tick & (state_q == TX_STOP) &
	                    (stop_second_q | ~control_one_q[C1_STOP_COUNT]);

	// ----------------------------------------------------------------
	// Transmitter state machine
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q       <= TX_IDLE;
			shift_q       <= 10'h000;
			bit_cnt_q     <= 4'h0;
			break_cnt_q   <= 4'h0;
			stop_second_q <= 1'b0;
		end else if (ce_i) begin
			if (!tx_active) begin
				state_q <= TX_IDLE;
				stop_second_q <= 1'b0;
			end else if (baud_tick) begin
				unique case (state_q)
					TX_IDLE: begin
						if (control_one_q[C1_BREAK]) begin
							state_q <= TX_BREAK;
							break_cnt_q <= 4'h0;
						end else if (data_full_q) begin
							shift_q   <= frame_word;
							bit_cnt_q <= 4'h0;
							state_q   <= TX_START;
						end
					end
					TX_START: state_q <= TX_DATA;
					TX_DATA: begin
						shift_q   <= {1'b0, shift_q[9:1]};
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == frame_bits - 4'h1) begin
							state_q <= TX_STOP;
						end
					end
					TX_STOP: begin
						stop_second_q <= ~stop_second_q & control_one_q[C1_STOP_COUNT];
						if (load_now) begin
							shift_q   <= frame_word;
							bit_cnt_q <= 4'h0;
							state_q   <= TX_START;
						end else if (frame_done) begin
							state_q <= TX_IDLE;
						end
					end
					TX_BREAK: begin
						break_cnt_q <= break_cnt_q + 4'h1;
						if (break_cnt_q == 4'(BREAK_BITS) &&
						    !control_one_q[C1_BREAK]) begin
							state_q <= TX_STOP;
						end else if (break_cnt_q == 4'(BREAK_BITS)) begin
							break_cnt_q <= 4'h0;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Data register and flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_q       <= 8'h00;
			data_ninth_q <= 1'b0;
			data_full_q  <= 1'b0;
		end else if (ce_i) begin
			if (!global_on) begin
				data_full_q <= 1'b0;
			end else if (load_now && !control_one_q[C1_BREAK]) begin
				data_full_q <= 1'b0;
			end else if (wr_data && transmit_empty_flag_q && status_seen_q) begin
				data_q       <= avs_writedata_i[7:0];
				data_ninth_q <= control_one_q[C1_NINTH_BIT];
				data_full_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_seen_q <= 1'b0;
		end else if (ce_i) begin
			if (rd_status) begin
				status_seen_q <= 1'b1;
			end else if (wr_data) begin
				status_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			transmit_empty_flag_q   <= 1'b1;
			transmitter_idle_flag_q <= 1'b1;
			receiver_idle_flag_q    <= 1'b1;
		end else if (ce_i) begin
			if (!global_on) begin
				transmit_empty_flag_q   <= 1'b1;
				transmitter_idle_flag_q <= 1'b1;
				receiver_idle_flag_q    <= 1'b1;
			end else begin
				if (load_now) begin
					transmit_empty_flag_q <= 1'b1;
				end else if (wr_data && status_seen_q && transmit_empty_flag_q) begin
					transmit_empty_flag_q <= 1'b0;
				end
				if (frame_done) begin
					transmitter_idle_flag_q <= 1'b1;
				end else if (wr_data && status_seen_q) begin
					transmitter_idle_flag_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_sync_q <= 2'b11;
		end else if (ce_i) begin
			rx_sync_q <= {rx_sync_q[0], rx_pin_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_pin_o    <= 1'b1;
			tx_pin_oe_o <= 1'b0;
			rx_owned_o  <= 1'b0;
			empty_irq_o <= 1'b0;
		end else if (ce_i) begin
			tx_pin_oe_o <= tx_active;
			rx_owned_o  <= global_on & control_two_q[C2_RECEIVE_ON];
			empty_irq_o <= transmit_empty_flag_q &
			               control_two_q[C2_EMPTY_IRQ];
			unique case (state_q)
				TX_START: tx_pin_o <= 1'b0;
				TX_DATA:  tx_pin_o <= shift_q[0];
				TX_BREAK: tx_pin_o <= 1'b0;
				default:  tx_pin_o <= 1'b1;
			endcase
		end
	end

endmodule

// ---- uart_format_enable_transmitter_properties.sv ----
// Checker for bus handshake and transmit pin behaviour
`timescale 1ns/1ns
module uart_tx_properties
	import uart_tx_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	// Avalon-MM slave
	input wire logic [3:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// Pins
	input wire logic        tx_pin_o,
	input wire logic        tx_pin_oe_o,
	input wire logic        rx_owned_o,
	input wire logic        empty_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ------------------------------------------------
	// Length of each low run on the owned line
	// ------------------------------------------------
	logic [11:0] low_run_q;
	always_ff @(posedge clk_i) begin
		if (srst_i || tx_pin_o || !tx_pin_oe_o) begin
			low_run_q <= 12'h000;
		end else if (low_run_q != 12'hFFF) begin
			low_run_q <= low_run_q + 12'h001;
		end
	end

	sequence s_taken;
		ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_one_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	sequence s_wr_taken;
		ce_i && avs_write_i && avs_waitrequest_o;
	endsequence

	property p_answer;
		s_taken |=> s_one_ack;
	endproperty
	property p_no_ack;
		!(avs_read_i || avs_write_i) |=> avs_waitrequest_o;
	endproperty
	property p_read_hold;
		!$past(avs_read_i) |-> $stable(avs_readdata_o);
	endproperty
	property p_reset;
		$fell(srst_i) |-> tx_pin_o && !tx_pin_oe_o && !empty_irq_o;
	endproperty
	property p_tx_off;
		s_wr_taken ##0 (avs_address_i == ADDR_CONTROL_TWO
			&& !avs_writedata_i[C2_TRANSMIT_ON]) |=> ##[0:2] !tx_pin_oe_o;
	endproperty
	property p_global_off;
		s_wr_taken ##0 (avs_address_i == ADDR_CONTROL_ONE
			&& !avs_writedata_i[31] && !avs_writedata_i[C1_GLOBAL_ON])
			|=> ##[0:2] (!tx_pin_oe_o && !rx_owned_o);
	endproperty
	property p_irq_off;
		s_wr_taken ##0 (avs_address_i == ADDR_CONTROL_TWO
			&& !avs_writedata_i[C2_EMPTY_IRQ]) |=> ##[0:2] !empty_irq_o;
	endproperty
	property p_bit_len;
		tx_pin_o && !$past(tx_pin_o) && tx_pin_oe_o && $past(tx_pin_oe_o)
			|-> low_run_q >= HIGH_SPEED_DIV;
	endproperty
	property p_idle_high;
		$rose(tx_pin_oe_o) |-> tx_pin_o;
	endproperty
	property p_freeze;
		!ce_i |=> $stable(tx_pin_o) && $stable(tx_pin_oe_o)
			&& $stable(avs_waitrequest_o);
	endproperty

	a_answer: assert property (p_answer)
		else $error("waitrequest did not drop for exactly one cycle");
	a_no_ack: assert property (p_no_ack)
		else $error("waitrequest low without a request");
	a_read_hold: assert property (p_read_hold)
		else $error("read data changed without a read");
	a_reset: assert property (p_reset)
		else $error("pins not idle after reset");
	a_tx_off: assert property (p_tx_off)
		else $error("transmit disable did not release the pin");
	a_global_off: assert property (p_global_off)
		else $error("global disable did not release the pins");
	a_irq_off: assert property (p_irq_off)
		else $error("empty request stayed with its enable clear");
	a_bit_len: assert property (p_bit_len)
		else $error("low run shorter than one bit time");
	a_idle_high: assert property (p_idle_high)
		else $error("line not high when taken over");
	a_freeze: assert property (p_freeze)
		else $error("outputs moved while the clock enable was low");
endmodule

bind uart_format_enable_transmitter uart_tx_properties u_props (
	.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
	.avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .tx_pin_o(tx_pin_o),
	.tx_pin_oe_o(tx_pin_oe_o), .rx_owned_o(rx_owned_o),
	.empty_irq_o(empty_irq_o)
);

// ---- uart_serial_peer.sv ----
// Remote serial receiver model at the far end of the line
`timescale 1ns/1ns
module uart_serial_peer (
	// Clock and line
	input  wire logic       clk_i,
	input  wire logic       line_i,
	input  wire logic       line_oe_i,
	// Frame format
	input  wire logic [9:0] bit_len_i,
	input  wire logic [3:0] nbits_i,
	input  wire logic [1:0] nstop_i,
	// Received frame
	output logic            valid_o = 1'b0,
	output logic [9:0]      word_o,
	output logic            stop_ok_o
);
	logic       busy_q = 1'b0;
	logic [9:0] cnt_q;
	logic [3:0] idx_q;

	// A released line abandons the frame being received
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		if (!line_oe_i) begin
			busy_q <= 1'b0;
		end else if (!busy_q) begin
			if (!line_i) begin
				busy_q <= 1'b1;
				cnt_q <= bit_len_i >> 1;
				idx_q <= 4'h0;
				word_o <= 10'h000;
			end
		end else if (cnt_q != 10'h000) begin
			cnt_q <= cnt_q - 10'h001;
		end else begin
			cnt_q <= bit_len_i - 10'h001;
			idx_q <= idx_q + 4'h1;
			if (idx_q == 4'h0) begin
				busy_q <= !line_i;
			end else if (idx_q <= nbits_i) begin
				word_o[idx_q - 4'h1] <= line_i;
			end else begin
				stop_ok_o <= (idx_q == nbits_i + 4'h1) ? line_i
					: (stop_ok_o & line_i);
				if (idx_q == nbits_i + 4'(nstop_i)) begin
					busy_q <= 1'b0;
					valid_o <= 1'b1;
				end
			end
		end
	end
endmodule

// ---- uart_format_enable_transmitter_tb.sv ----
// Self-checking bench for the transmitter block
`timescale 1ns/1ns
module uart_format_enable_transmitter_tb;
	import uart_tx_pkg::*;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic        waitreq, tx, oe, rx_owned, irq, pv, pstop;
	logic [9:0]  pword;
	logic [9:0]  bit_len = 10'h010;
	logic [3:0]  nbits = 4'h8;
	logic [1:0]  nstop = 2'h1;
	logic [9:0]  exp_q[$];
	logic [31:0] seed = 32'h000180BB;
	int          n_errors = 0;
	int          num_checks = 0;
	wire         line = oe ? tx : 1'b1;

	initial forever #25 clk_i = ~clk_i;

	uart_format_enable_transmitter DUT (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .rx_pin_i(line), .tx_pin_o(tx),
		.tx_pin_oe_o(oe), .rx_owned_o(rx_owned), .empty_irq_o(irq)
	);
	uart_serial_peer peer (
		.clk_i(clk_i), .line_i(line), .line_oe_i(oe), .bit_len_i(bit_len),
		.nbits_i(nbits), .nstop_i(nstop), .valid_o(pv), .word_o(pword),
		.stop_ok_o(pstop)
	);

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [9:0] fword(input logic [7:0] b,
		input logic [7:0] c);
		logic p;
		p = (c[C1_WORD_LENGTH] ? ^b : ^b[6:0]) ^ c[C1_PARITY_TYPE];
		if (!c[C1_PARITY_ON])
			p = c[C1_WORD_LENGTH] ? c[C1_NINTH_BIT] : b[7];
		return c[C1_WORD_LENGTH] ? {1'b0, p, b} : {2'b00, p, b[6:0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge clk_i);
		addr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (waitreq === 1'b0) break;
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (i == 20) begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rreg(input logic [3:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	task automatic send(input logic [7:0] b, input logic [7:0] c);
		logic [31:0] q;
		rreg(ADDR_STATUS, q);
		wreg(ADDR_DATA, {24'h800000, b});
		exp_q.push_back(fword(b, c));
	endtask

	task automatic cfg(input logic [7:0] c1, input logic [7:0] c2,
		input logic [7:0] dv);
		wreg(ADDR_DIVISOR, {24'h0, dv});
		wreg(ADDR_CONTROL_ONE, {24'h0, c1});
		wreg(ADDR_CONTROL_TWO, {24'h0, c2});
		bit_len = (c2[C2_HIGH_SPEED] ? 10'd16 : 10'd64) * (10'(dv) + 10'd1);
		nbits = c1[C1_WORD_LENGTH] ? 4'h9 : 4'h8;
		nstop = c1[C1_STOP_COUNT] ? 2'h2 : 2'h1;
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 6000 && exp_q.size() != 0; i++) @(posedge clk_i);
		if (i == 6000) begin
			n_errors++;
			test_done();
		end
		repeat (4 * bit_len) @(posedge clk_i);
	endtask

	// Frames seen by the peer are matched against the oldest note
	always @(posedge clk_i) begin
		if (pv === 1'b1) begin
			if (exp_q.size() == 0) begin
				check({22'h0, pword}, 32'hFFFFFFFF);
			end else begin
				check({22'h0, pword}, {22'h0, exp_q.pop_front()});
				check({31'h0, pstop}, 32'h1);
			end
		end
	end

	initial begin
		logic [31:0] q;
		logic [7:0]  c1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		// ------------------------------------------------
		// Reset values
		// ------------------------------------------------
		rreg(ADDR_STATUS, q);
		check(q[2:0], 3'h7);
		rreg(ADDR_CONTROL_ONE, q);
		check(q[7:0], C1_RESET);
		rreg(4'h2, q);
		check(q, 32'h0);
		// A request with the clock enable low is not answered
		@(posedge clk_i);
		ce_i <= 1'b0;
		addr <= ADDR_STATUS;
		rd   <= 1'b1;
		repeat (5) @(posedge clk_i);
		check({31'h0, waitreq}, 32'h1);
		rd   <= 1'b0;
		ce_i <= 1'b1;
		$display("test reset done");
		// ------------------------------------------------
		// Every format and parity, both speed settings
		// ------------------------------------------------
		for (int i = 0; i < 16; i++) begin
			q = xorshift();
			c1 = {1'b1, i[0], i[1], i[2], i[3], 2'b00, q[0]};
			cfg(c1, {2'b11, i != 15, 5'h00}, {7'h0, i[0]});
			send(q[15:8], c1);
			wait_done();
		end
		$display("test formats done");
		// ------------------------------------------------
		// Write before enable, back to back, refusals
		// ------------------------------------------------
		cfg(8'h88, 8'h61, 8'h01);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq}, 32'h1);
		send(8'hA5, 8'h88);
		repeat (200) @(posedge clk_i);
		check(exp_q.size(), 32'h1);
		wreg(ADDR_CONTROL_TWO, 32'hE1);
		wait_done();
		send(8'h3C, 8'h88);
		repeat (bit_len) @(posedge clk_i);
		rreg(ADDR_STATUS, q);
		check(q[1:0], 2'h1);
		wreg(ADDR_DATA, 32'h800000C3);
		exp_q.push_back(10'h0C3);
		rreg(ADDR_STATUS, q);
		check(q[ST_EMPTY], 1'b0);
		check({31'h0, irq}, 32'h0);
		wreg(ADDR_DATA, 32'h8000005A);
		wait_done();
		send(8'h69, 8'h88);
		wait_done();
		wreg(ADDR_DATA, 32'h80000096);
		wait_done();
		rreg(ADDR_STATUS, q);
		check(q[1:0], 2'h3);
		$display("test buffering done");
		// ------------------------------------------------
		// Abort by global disable, then resume
		// ------------------------------------------------
		rreg(ADDR_STATUS, q);
		wreg(ADDR_DATA, 32'h800000F0);
		repeat (40) @(posedge clk_i);
		wreg(ADDR_CONTROL_ONE, 32'h58);
		rreg(ADDR_STATUS, q);
		check(q[2:0], 3'h7);
		rreg(ADDR_CONTROL_TWO, q);
		check(q[7:0], 8'h21);
		rreg(ADDR_DIVISOR, q);
		check(q[7:0], 8'h01);
		rreg(ADDR_CONTROL_ONE, q);
		check(q[7:0], 8'h58);
		wreg(ADDR_CONTROL_ONE, 32'h88);
		wreg(ADDR_CONTROL_TWO, 32'hE1);
		send(8'h81, 8'h88);
		wait_done();
		$display("test abort done");
		test_done();
	end
endmodule
